// [include/rmc_defs.svh]
// Link constants
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH
`define RMC_HDR        8'hff
`define RMC_SIZE       8'h02
`define RMC_ESC        8'hfe
`define RMC_ACK        8'h06
`define RMC_TRIG_V     8'h54
`define RMC_TRIG_S     8'h09
`define RMC_BANNER_S   8'h0a
`define RMC_CS_V       8'h56
`define RMC_CS_S       8'h0b
`define RMC_PWR_V      8'h58
`define RMC_PWR_S      8'h0d
`define RMC_WACK_V     8'h59
`define RMC_WACK_S     8'h0e
`define RMC_OFF        8'h00
`define RMC_ON         8'h01
`define RMC_TRIG_RST   8'h40
`define RMC_TRIG_MIN   8'h01
`define RMC_TRIG_MAX   8'hc0
`define RMC_BANNER_RST 8'h01
`define RMC_CS_RST     8'h01
`define RMC_PWR_RST    8'h00
`define RMC_WACK_RST   8'h01
`define RMC_PKT_TX_BIT 0
`define RMC_FIFO_W     8
`define RMC_FIFO_D     32
`define RMC_BANNER_LEN 2'h3
`define RMC_BANNER_TXT 32'h76310d0a
`endif

// [include/rmc_link_if.sv]
// Serial byte link between host and radio module
`timescale 1ns/1ps
`default_nettype none
interface rmc_link_if;
    logic [7:0] h2d_data;
    logic       h2d_valid;
    logic       h2d_ready;
    logic [7:0] d2h_data;
    logic       d2h_valid;
    logic       d2h_ready;
    modport dev  (input h2d_data, h2d_valid, d2h_ready,
                  output h2d_ready, d2h_data, d2h_valid);
    modport host (output h2d_data, h2d_valid, d2h_ready,
                  input h2d_ready, d2h_data, d2h_valid);
endinterface
`default_nettype wire

// [include/rmc_pkg.sv]
// Types shared by both ends of the configuration link
package rmc_pkg;
    typedef enum logic [9:0] {
        ST_BANNER   = 10'h001,
        ST_WAKE_ACK_SELECT  = 10'h002,
        ST_IDLE     = 10'h004,
        ST_SIZE     = 10'h008,
        ST_ESC_ADDR = 10'h010,
        ST_RADDR    = 10'h020,
        ST_VALUE    = 10'h040,
        ST_RSP_ACK  = 10'h080,
        ST_RSP_ADDR = 10'h100,
        ST_RSP_VAL  = 10'h200
    } rmc_dev_state_t;

    typedef enum logic [5:0] {
        HS_WAIT  = 6'h01,
        HS_IDLE  = 6'h02,
        HS_SEND  = 6'h04,
        HS_RACK  = 6'h08,
        HS_RADDR = 6'h10,
        HS_RVAL  = 6'h20
    } rmc_host_state_t;

    typedef struct packed {
        rmc_dev_state_t state;
        logic [7:0]     addr;
        logic [7:0]     rdata;
        logic [7:0]     tx_byte;
        logic [1:0]     bidx;
        logic [7:0]     trig;
        logic [7:0]     trig_s;
        logic [7:0]     banner_s;
        logic [7:0]     cs;
        logic [7:0]     cs_s;
        logic [7:0]     pwr;
        logic [7:0]     pwr_s;
        logic [7:0]     wack;
        logic [7:0]     wack_s;
        logic           tx_on;
        logic [7:0]     tx_left;
    } rmc_dev_t;

    typedef struct packed {
        rmc_host_state_t  state;
        logic [3:0][7:0]  seq;
        logic [1:0]       last;
        logic [1:0]       idx;
        logic             is_read;
        logic             rewait;
        logic [7:0]       rsp_data;
        logic             rsp_valid;
        logic [7:0]       rx_data;
        logic             rx_valid;
    } rmc_host_t;
endpackage

// [rtl/rmc_device.sv]
// Radio module end: command parser, settings, data FIFO, transmit trigger
//
// Contract
// - Transmit when buffer reaches trigger, 1..192; here the FIFO holds 32 bytes, so a trigger above 32 never starts one
// - Trigger resets to 64
// - Host should use 128 at top rate
// - Trigger is minimum; remainder goes next channel
// - Packet option bit 0 overrides trigger
// - Framed read and write with ACK reply; here only a read replies (ACK, address, value), a write gets none
// - Trigger at 0x54 and 0x09, same value
// - Banner setting only stored, at 0x0A
// - Banner 0 silent, 1 sends version message
// - Input discarded while banner is sent
// - Carrier sense: wait while channel busy
// - Carrier sense 0 off, 1 on, default on
// - Idle 0 awake, 1 sleep; radio awake only
// - Sleep disables all radio circuitry
// - Corrupt state on wake forces soft reboot
// - Wake acknowledge 0x06 after reset or wake
// - Wake acknowledge follows the banner message
// - Host holds traffic until wake acknowledge
// - Zero timeout: send all at trigger count
`include "rmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rmc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic [W-1:0]           in_data,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    output logic [W-1:0]                out_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [$clog2(D):0]          count
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } rmc_fifo_t;
    rmc_fifo_t r_reg, r_next;
    logic      wr;
    logic      rd;

    assign in_ready  = (r_reg.cnt != D[AW:0]);
    assign out_valid = (r_reg.cnt != '0);
    assign out_data  = r_reg.mem[r_reg.rp];
    assign count     = r_reg.cnt;

    always_comb begin
        r_next = r_reg;
        wr     = in_valid && in_ready;
        rd     = out_valid && out_ready;
        if (wr) begin
            r_next.mem[r_reg.wp] = in_data;
            r_next.wp            = r_reg.wp + 1'b1;
        end
        if (rd) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule // rmc_fifo

////////////////////////////////////////////////////////////////////////////////
module rmc_device (
    input  wire logic       clock,
    input  wire logic       rst_n,
    rmc_link_if.dev         lk,
    input  wire logic [7:0] packet_option_reg,
    input  wire logic       pkt_flush,
    input  wire logic       channel_busy,
    input  wire logic       dwell_room,
    input  wire logic       state_corrupt,
    output logic [7:0]      radio_tx_data,
    output logic            radio_tx_valid,
    input  wire logic       radio_tx_ready,
    output logic            radio_enable,
    output logic            tx_active
);
    localparam rmc_pkg::rmc_dev_t NV_DEF = '{
        state: rmc_pkg::ST_IDLE, trig_s: `RMC_TRIG_RST, banner_s: `RMC_BANNER_RST,
        cs_s: `RMC_CS_RST, pwr_s: `RMC_PWR_RST, wack_s: `RMC_WACK_RST, default: '0};

    rmc_pkg::rmc_dev_t r_reg, r_next;
    logic [7:0]        fifo_in_data;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_pop;
    logic [5:0]        fifo_count;
    logic              in_ok;
    logic              awake;
    logic              start_ok;

    function automatic logic [7:0] out_byte(input rmc_pkg::rmc_dev_t s);
        case (s.state)
            rmc_pkg::ST_BANNER:   out_byte = 8'(`RMC_BANNER_TXT >> {s.bidx ^ 2'h3, 3'h0});
            rmc_pkg::ST_RSP_ADDR: out_byte = s.addr;
            rmc_pkg::ST_RSP_VAL:  out_byte = s.rdata;
            default:              out_byte = `RMC_ACK;
        endcase
    endfunction

    // Reboot reloads working copies
    function automatic rmc_pkg::rmc_dev_t boot(input rmc_pkg::rmc_dev_t s);
        boot       = s;
        boot.trig  = s.trig_s;
        boot.cs    = s.cs_s;
        boot.pwr   = s.pwr_s;
        boot.wack  = s.wack_s;
        boot.bidx  = '0;
        boot.tx_on = 1'b0;
        boot.state = (s.banner_s == `RMC_ON) ? rmc_pkg::ST_BANNER : rmc_pkg::ST_WAKE_ACK_SELECT;
        boot.tx_byte = out_byte(boot);
    endfunction

    function automatic logic [7:0] rd_val(input rmc_pkg::rmc_dev_t s, input logic [7:0] a);
        if (a == `RMC_TRIG_V) rd_val = s.trig;
        else if (a == `RMC_TRIG_S) rd_val = s.trig_s;
        else if (a == `RMC_BANNER_S) rd_val = s.banner_s;
        else if (a == `RMC_CS_V) rd_val = s.cs;
        else if (a == `RMC_CS_S) rd_val = s.cs_s;
        else if (a == `RMC_PWR_V) rd_val = s.pwr;
        else if (a == `RMC_PWR_S) rd_val = s.pwr_s;
        else if (a == `RMC_WACK_V) rd_val = s.wack;
        else if (a == `RMC_WACK_S) rd_val = s.wack_s;
        else rd_val = 8'h00;
    endfunction

    rmc_fifo #(.W(`RMC_FIFO_W), .D(`RMC_FIFO_D)) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_data   (fifo_in_data),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (radio_tx_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .count     (fifo_count)
    );

    assign awake        = (r_reg.pwr == `RMC_OFF);
    assign radio_enable = awake;
    assign tx_active    = r_reg.tx_on;
    assign fifo_in_data = lk.h2d_data;
    assign lk.d2h_data  = r_reg.tx_byte;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        lk.d2h_valid = (r_reg.state == rmc_pkg::ST_BANNER) ||
                       (r_reg.state == rmc_pkg::ST_RSP_ACK) ||
                       (r_reg.state == rmc_pkg::ST_RSP_ADDR) ||
                       (r_reg.state == rmc_pkg::ST_RSP_VAL) ||
                       (r_reg.state == rmc_pkg::ST_WAKE_ACK_SELECT && r_reg.wack == `RMC_ON);
        case (r_reg.state)
            rmc_pkg::ST_IDLE:     lk.h2d_ready = (lk.h2d_data == `RMC_HDR) || fifo_in_ready;
            rmc_pkg::ST_RSP_ACK,
            rmc_pkg::ST_RSP_ADDR,
            rmc_pkg::ST_RSP_VAL:  lk.h2d_ready = 1'b0;
            default:              lk.h2d_ready = 1'b1;
        endcase
        in_ok          = lk.h2d_valid && lk.h2d_ready;
        fifo_in_valid  = lk.h2d_valid && (r_reg.state == rmc_pkg::ST_IDLE) &&
                         (lk.h2d_data != `RMC_HDR);
        radio_tx_valid = r_reg.tx_on && awake && dwell_room && fifo_out_valid;
        fifo_pop       = radio_tx_valid && radio_tx_ready;
        // Trigger level, or flush under packet option
        start_ok = awake && !r_reg.tx_on && (fifo_count != '0) &&
                   (packet_option_reg[`RMC_PKT_TX_BIT] ? pkt_flush :
                    ({2'b00, fifo_count} >= r_reg.trig)) &&
                   !(r_reg.cs == `RMC_ON && channel_busy);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_next = r_reg;
        case (r_reg.state)
            rmc_pkg::ST_BANNER: begin
                if (lk.d2h_ready) begin
                    r_next.bidx = r_reg.bidx + 2'h1;
                    if (r_reg.bidx == `RMC_BANNER_LEN) begin
                        r_next.state = rmc_pkg::ST_WAKE_ACK_SELECT;
                    end
                end
            end
            rmc_pkg::ST_WAKE_ACK_SELECT: begin
                if (r_reg.wack != `RMC_ON || lk.d2h_ready) begin
                    r_next.state = rmc_pkg::ST_IDLE;
                end
            end
            rmc_pkg::ST_IDLE: begin
                if (in_ok && lk.h2d_data == `RMC_HDR) begin
                    r_next.state = rmc_pkg::ST_SIZE;
                end
            end
            rmc_pkg::ST_SIZE: begin
                if (in_ok) begin
                    r_next.state = (lk.h2d_data == `RMC_SIZE) ? rmc_pkg::ST_ESC_ADDR
                                                               : rmc_pkg::ST_IDLE;
                end
            end
            rmc_pkg::ST_ESC_ADDR: begin
                if (in_ok) begin
                    r_next.addr  = lk.h2d_data;
                    r_next.state = (lk.h2d_data == `RMC_ESC) ? rmc_pkg::ST_RADDR
                                                              : rmc_pkg::ST_VALUE;
                end
            end
            rmc_pkg::ST_RADDR: begin
                if (in_ok) begin
                    r_next.addr  = lk.h2d_data;
                    r_next.rdata = rd_val(r_reg, lk.h2d_data);
                    r_next.state = rmc_pkg::ST_RSP_ACK;
                end
            end
            rmc_pkg::ST_VALUE: begin
                if (in_ok) begin
                    r_next.state = rmc_pkg::ST_IDLE;
                    if (r_reg.addr == `RMC_TRIG_V || r_reg.addr == `RMC_TRIG_S) begin
                        if (lk.h2d_data >= `RMC_TRIG_MIN && lk.h2d_data <= `RMC_TRIG_MAX) begin
                            r_next.trig   = lk.h2d_data;
                            r_next.trig_s = lk.h2d_data;
                        end
                    end else if (r_reg.addr == `RMC_BANNER_S) begin
                        r_next.banner_s = lk.h2d_data;
                    end else if (r_reg.addr == `RMC_CS_V) begin
                        r_next.cs = lk.h2d_data;
                    end else if (r_reg.addr == `RMC_CS_S) begin
                        r_next.cs_s = lk.h2d_data;
                    end else if (r_reg.addr == `RMC_PWR_V) begin
                        r_next.pwr = lk.h2d_data;
                        if (!awake && lk.h2d_data == `RMC_OFF) begin
                            r_next.state = rmc_pkg::ST_WAKE_ACK_SELECT;
                        end
                    end else if (r_reg.addr == `RMC_PWR_S) begin
                        r_next.pwr_s = lk.h2d_data;
                    end else if (r_reg.addr == `RMC_WACK_V) begin
                        r_next.wack = lk.h2d_data;
                    end else if (r_reg.addr == `RMC_WACK_S) begin
                        r_next.wack_s = lk.h2d_data;
                    end
                end
            end
            rmc_pkg::ST_RSP_ACK: begin
                if (lk.d2h_ready) r_next.state = rmc_pkg::ST_RSP_ADDR;
            end
            rmc_pkg::ST_RSP_ADDR: begin
                if (lk.d2h_ready) r_next.state = rmc_pkg::ST_RSP_VAL;
            end
            rmc_pkg::ST_RSP_VAL: begin
                if (lk.d2h_ready) r_next.state = rmc_pkg::ST_IDLE;
            end
            default: r_next.state = rmc_pkg::ST_IDLE;
        endcase

        // Burst length fixed at start; dwell end pauses it
        if (start_ok) begin
            r_next.tx_on   = 1'b1;
            r_next.tx_left = {2'b00, fifo_count};
        end else if (fifo_pop) begin
            r_next.tx_left = r_reg.tx_left - 8'h01;
            if (r_reg.tx_left == 8'h01) r_next.tx_on = 1'b0;
        end

        r_next.tx_byte = out_byte(r_next);
        if (r_reg.state == rmc_pkg::ST_VALUE && r_next.state == rmc_pkg::ST_WAKE_ACK_SELECT &&
            state_corrupt) begin
            r_next = boot(r_reg);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r_reg <= boot(NV_DEF);
        end else begin
            r_reg <= r_next;
        end
    end
endmodule // rmc_device
`default_nettype wire

// [rtl/rmc_host.sv]
// Host end: frames register commands and data, parses replies
`include "rmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rmc_host (
    input  wire logic       clock,
    input  wire logic       rst_n,
    rmc_link_if.host        lk,
    input  wire logic       wait_for_ack,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_write,
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    output logic            cmd_ready,
    output logic [7:0]      rsp_data,
    output logic            rsp_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            dev_ready
);
    rmc_pkg::rmc_host_t r_reg, r_next;
    logic               got;
    logic               idle;

    assign idle         = (r_reg.state == rmc_pkg::HS_IDLE);
    assign dev_ready    = idle;
    assign cmd_ready    = idle;
    assign tx_ready     = idle && !cmd_valid;
    assign lk.h2d_valid = (r_reg.state == rmc_pkg::HS_SEND);
    assign lk.h2d_data  = r_reg.seq[r_reg.idx];
    assign lk.d2h_ready = 1'b1;
    assign got          = lk.d2h_valid;
    assign rsp_data     = r_reg.rsp_data;
    assign rsp_valid    = r_reg.rsp_valid;
    assign rx_data      = r_reg.rx_data;
    assign rx_valid     = r_reg.rx_valid;

    always_comb begin
        r_next           = r_reg;
        r_next.rsp_valid = 1'b0;
        r_next.rx_valid  = 1'b0;
        r_next.rx_data   = lk.d2h_data;
        if (got) r_next.rx_valid = 1'b1;
        case (r_reg.state)
            rmc_pkg::HS_WAIT: begin
                // Banner bytes pass to rx; traffic held until acknowledge
                if (!wait_for_ack || (got && lk.d2h_data == `RMC_ACK)) begin
                    r_next.state    = rmc_pkg::HS_IDLE;
                    r_next.rx_valid = 1'b0;
                end
            end
            rmc_pkg::HS_IDLE: begin
                r_next.idx = 2'h0;
                if (cmd_valid) begin
                    r_next.state   = rmc_pkg::HS_SEND;
                    r_next.last    = 2'h3;
                    r_next.is_read = !cmd_write;
                    r_next.rewait  = cmd_write && cmd_addr == `RMC_PWR_V &&
                                     cmd_wdata == `RMC_OFF;
                    r_next.seq = cmd_write ? {cmd_wdata, cmd_addr, `RMC_SIZE, `RMC_HDR}
                                           : {cmd_addr, `RMC_ESC, `RMC_SIZE, `RMC_HDR};
                end else if (tx_valid) begin
                    r_next.state   = rmc_pkg::HS_SEND;
                    r_next.last    = 2'h0;
                    r_next.is_read = 1'b0;
                    r_next.rewait  = 1'b0;
                    r_next.seq[0]  = tx_data;
                end
            end
            rmc_pkg::HS_SEND: begin
                if (lk.h2d_ready) begin
                    r_next.idx = r_reg.idx + 2'h1;
                    if (r_reg.idx == r_reg.last) begin
                        if (r_reg.is_read) r_next.state = rmc_pkg::HS_RACK;
                        else if (r_reg.rewait && wait_for_ack) r_next.state = rmc_pkg::HS_WAIT;
                        else r_next.state = rmc_pkg::HS_IDLE;
                    end
                end
            end
            rmc_pkg::HS_RACK: begin
                if (got && lk.d2h_data == `RMC_ACK) begin
                    r_next.state    = rmc_pkg::HS_RADDR;
                    r_next.rx_valid = 1'b0;
                end
            end
            rmc_pkg::HS_RADDR: begin
                if (got) begin
                    r_next.state    = rmc_pkg::HS_RVAL;
                    r_next.rx_valid = 1'b0;
                end
            end
            rmc_pkg::HS_RVAL: begin
                if (got) begin
                    r_next.state     = rmc_pkg::HS_IDLE;
                    r_next.rx_valid  = 1'b0;
                    r_next.rsp_valid = 1'b1;
                    r_next.rsp_data  = lk.d2h_data;
                end
            end
            default: r_next.state = rmc_pkg::HS_WAIT;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r_reg       <= '0;
            r_reg.state <= rmc_pkg::HS_WAIT;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule // rmc_host
`default_nettype wire

// [tb/radio_module_config_regs_tb_top.sv]
// Bench joining both ends
`include "rmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module radio_module_config_regs_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0, cmd_write = 1'b0, tx_valid = 1'b0, pkt_flush = 1'b0;
    logic busy = 1'b0, corrupt = 1'b0, dwell = 1'b1, radio_ready = 1'b1;
    logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, tx_data = 8'h00, pkt_opt = 8'h00;
    logic cmd_ready, rsp_valid, tx_ready, dev_ready, radio_valid, radio_enable, tx_active;
    logic [7:0] rsp_data, radio_data, v, x, r;
    logic [7:0] sent_q[$];
    int mismatches = 0, check_count = 0, n;
    bit ok;
    localparam logic [7:0] RA [9] = '{8'h54, 8'h09, 8'h56, 8'h0b, 8'h59, 8'h0e, 8'h58, 8'h0a, 8'h30};
    localparam logic [7:0] RE [9] = '{8'h40, 8'h40, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
    localparam logic [7:0] TW [6] = '{8'h00, 8'hc1, 8'hc0, 8'h00, 8'h80, 8'h03};
    rmc_link_if rmc_link_if_i ();
    rmc_device rmc_device_i (.clock(clock), .rst_n(rst_n), .lk(rmc_link_if_i.dev),
        .packet_option_reg(pkt_opt), .pkt_flush(pkt_flush), .channel_busy(busy),
        .dwell_room(dwell), .state_corrupt(corrupt), .radio_tx_data(radio_data),
        .radio_tx_valid(radio_valid), .radio_tx_ready(radio_ready),
        .radio_enable(radio_enable), .tx_active(tx_active));
    rmc_host rmc_host_i (.clock(clock), .rst_n(rst_n), .lk(rmc_link_if_i.host),
        .wait_for_ack(1'b1), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(), .rx_valid(), .dev_ready(dev_ready));
    rmc_link_sva rmc_link_sva_i (.clock(clock), .rst_n(rst_n),
        .h2d_data(rmc_link_if_i.h2d_data), .h2d_valid(rmc_link_if_i.h2d_valid),
        .h2d_ready(rmc_link_if_i.h2d_ready), .d2h_data(rmc_link_if_i.d2h_data),
        .d2h_valid(rmc_link_if_i.d2h_valid), .d2h_ready(rmc_link_if_i.d2h_ready));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] next_trig(input logic [7:0] cur, input logic [7:0] req);
        return (req >= 8'h01 && req <= 8'hc0) ? req : cur;
    endfunction
    task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        cmd_valid = 1'b0;
        q = 8'h00;
        if (!w) begin
            while (rsp_valid !== 1'b1) @(negedge clock);
            q = rsp_data;
        end
    endtask
    // One payload byte; gives up after 60 refusals
    task automatic send(output bit acc);
        @(negedge clock);
        tx_data = 8'($urandom_range(0, 254));
        tx_valid = 1'b1;
        for (int k = 0; tx_ready !== 1'b1 && k < 60; k++)
            @(negedge clock);
        acc = tx_ready === 1'b1;
        if (acc) begin
            sent_q.push_back(tx_data);
            @(negedge clock);
        end
        tx_valid = 1'b0;
    endtask
    task automatic drain();
        for (int k = 0; k < 400 && (sent_q.size() != 0 || tx_active !== 1'b0); k++)
            @(negedge clock);
        chk("drained", 8'(sent_q.size()), 8'h00);
    endtask
    task automatic wake(input logic bad);
        corrupt = bad;
        cmd(1'b1, `RMC_PWR_V, 8'h00, r);
        for (n = 0; dev_ready !== 1'b1 && n < 200; n++)
            @(negedge clock);
        corrupt = 1'b0;
        chk("wake_ready", {7'h0, dev_ready}, 8'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always #2 clock = ~clock;
    always @(negedge clock) begin
        radio_ready <= ($urandom % 4) != 0;
        dwell <= ($urandom % 8) != 0;
    end
    always @(posedge clock) begin
        if (rst_n && radio_valid && radio_ready) begin
            chk("radio_byte", radio_data, sent_q.size() > 0 ? sent_q.pop_front() : 8'hxx);
        end
    end
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
    initial begin
        void'($urandom(64));
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        foreach (RA[i]) begin
            cmd(1'b0, RA[i], 8'h00, v);
            chk("reset_value", v, RE[i]);
        end
        v = 8'h40;
        foreach (TW[i]) begin
            x = (i == 3) ? 8'($urandom_range(1, 192)) : TW[i];
            cmd(1'b1, i[0] ? `RMC_TRIG_S : `RMC_TRIG_V, x, r);
            v = next_trig(v, x);
            cmd(1'b0, `RMC_TRIG_V, 8'h00, x);
            chk("trigger_volatile", x, v);
            cmd(1'b0, `RMC_TRIG_S, 8'h00, x);
            chk("trigger_stored", x, v);
        end
        repeat (2) send(ok);
        repeat (15) @(negedge clock);
        chk("below_trigger", 8'(sent_q.size()), 8'h02);
        for (int c = 1; c >= 0; c--) begin
            cmd(1'b1, `RMC_CS_V, 8'(c), r);
            busy = 1'b1;
            repeat (3) send(ok);
            repeat (30) @(negedge clock);
            chk("carrier_hold", 8'(sent_q.size()), c ? 8'h05 : 8'h00);
            busy = 1'b0;
            drain();
        end
        pkt_opt = 8'h01;
        n = 0;
        do begin
            send(ok);
            n += ok;
        end while (ok && n < 40);
        chk("fifo_fill", 8'(n), 8'h21);
        pkt_flush = 1'b1;
        drain();
        pkt_flush = 1'b0;
        pkt_opt = 8'h00;
        cmd(1'b1, `RMC_PWR_V, 8'h01, r);
        cmd(1'b0, `RMC_PWR_V, 8'h00, x);
        chk("sleep_value", x, 8'h01);
        chk("radio_off", {7'h0, radio_enable}, 8'h00);
        repeat (3) send(ok);
        repeat (20) @(negedge clock);
        chk("asleep_hold", 8'(sent_q.size()), 8'h03);
        wake(1'b0);
        drain();
        chk("radio_on", {7'h0, radio_enable}, 8'h01);
        cmd(1'b1, `RMC_CS_V, 8'h01, r);
        cmd(1'b1, `RMC_CS_S, 8'h00, r);
        cmd(1'b1, `RMC_PWR_V, 8'h01, r);
        wake(1'b1);
        cmd(1'b0, `RMC_CS_V, 8'h00, x);
        chk("reboot_carrier", x, 8'h00);
        wrap_up();
    end
endmodule // radio_module_config_regs_tb_top
`default_nettype wire

// [tb/rmc_link_sva.sv]
// Link assertions
`include "rmc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rmc_link_sva (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] h2d_data,
    input wire logic       h2d_valid,
    input wire logic       h2d_ready,
    input wire logic [7:0] d2h_data,
    input wire logic       d2h_valid,
    input wire logic       d2h_ready
);
    localparam logic [39:0] BOOT = {`RMC_BANNER_TXT, `RMC_ACK};
    logic [23:0] hist_reg;
    logic [2:0]  boot_reg;
    logic        sleep_reg;
    wire         h_take = h2d_valid && h2d_ready;
    wire         d_take = d2h_valid && d2h_ready;
    wire         rd_go = h_take && hist_reg == {`RMC_HDR, `RMC_SIZE, `RMC_ESC};
    wire         pwr = h_take && hist_reg == {`RMC_HDR, `RMC_SIZE, `RMC_PWR_V};
    // Host byte history, boot progress, sleep
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hist_reg <= '0;
            boot_reg <= '0;
            sleep_reg <= 1'b0;
        end else begin
            if (h_take) hist_reg <= {hist_reg[15:0], h2d_data};
            if (d_take && boot_reg < 3'h5) boot_reg <= boot_reg + 3'h1;
            if (pwr) sleep_reg <= h2d_data != `RMC_OFF;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    AST_BOOT_SEQ: assert property (d_take && boot_reg < 3'h5
        |-> d2h_data == BOOT[39 - 8 * boot_reg -: 8]) else $error("boot byte wrong");
    AST_BOOT_PROMPT: assert property ($rose(rst_n) |-> ##[0:2] d2h_valid)
        else $error("no boot message");
    AST_READ_REPLY: assert property (rd_go |=> d2h_valid && d2h_data == `RMC_ACK
        ##1 d2h_valid && d2h_data == $past(h2d_data, 2) ##1 d2h_valid)
        else $error("bad read reply");
    AST_READ_BUSY: assert property (rd_go |=> !h2d_ready [*3])
        else $error("byte taken during reply");
    AST_H2D_HOLD: assert property (h2d_valid && !h2d_ready
        |=> h2d_valid && $stable(h2d_data)) else $error("host byte dropped");
    AST_SIZE_NEXT: assert property (h_take && h2d_data == `RMC_HDR
        |=> h2d_valid && h2d_data == `RMC_SIZE) else $error("size byte missing");
    AST_WAKE_ACK: assert property (pwr && sleep_reg && h2d_data == `RMC_OFF
        |-> ##[1:8] d_take && d2h_data == `RMC_ACK) else $error("no wake ack");
    AST_HOLD_TRAFFIC: assert property (boot_reg < 3'h5 |-> !h2d_valid)
        else $error("host sent before ack");
endmodule // rmc_link_sva
`default_nettype wire
